// ---- core/sbd_pkg.sv ----
// Purpose: shared constants and types of the serial port baud and data block
// Assumes: word-indexed APB map, byte address is four times the index
// Notes: oversampling figures are ticks of the baud counter per bit
package sbd_pkg;

  // Register indices, byte address = index * 4
  localparam logic [11:0] IDX_RX_DATA = 12'hF98;
  localparam logic [11:0] IDX_TX_DATA = 12'hF99;
  localparam logic [11:0] IDX_DIV_LO = 12'hF9A;
  localparam logic [11:0] IDX_DIV_HI = 12'hF9B;
  localparam logic [11:0] IDX_BAUD_CTL = 12'hF9E;
  localparam logic [11:0] IDX_IRQ_STAT = 12'hFA0;
  localparam logic [11:0] IDX_IRQ_EN = 12'hFA1;
  localparam logic [11:0] IDX_IRQ_CLR = 12'hFA2;
  localparam logic [11:0] IDX_PORT_CTL = 12'hFA3;

  // Baud control field positions
  localparam int BC_OVF = 7;
  localparam int BC_IDLE = 6;
  localparam int BC_POL = 4;
  localparam int BC_WIDE = 3;
  localparam int BC_WAKE = 1;
  localparam int BC_ABD = 0;

  // Port control field positions
  localparam int PC_EN = 0;
  localparam int PC_SYNC = 1;
  localparam int PC_HS = 2;

  // Interrupt status bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_N = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;

  // Ticks per bit and auto-baud scaling (log2 of 8 bit times)
  localparam logic [6:0] OS_FAST = 7'h04;
  localparam logic [6:0] OS_MID = 7'h10;
  localparam logic [6:0] OS_SLOW = 7'h40;
  localparam logic [3:0] ABD_SH_FAST = 4'h5;
  localparam logic [3:0] ABD_SH_MID = 4'h7;
  localparam logic [3:0] ABD_SH_SLOW = 4'h9;
  localparam int ABD_W = 25;
  localparam logic [2:0] ABD_LAST_RISE = 3'h3;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic autobaud_overflow_flag;
    logic polarity_edge_select;
    logic wide_divider_select;
    logic wake_on_edge_enable;
    logic autobaud_enable;
  } sbd_baud_ctl_t;

  typedef struct packed {
    logic high_speed_select;
    logic mode_sync;
    logic port_enable;
  } sbd_port_ctl_t;

  typedef enum logic [3:0] {
    R_IDLE = 4'h1,
    R_START = 4'h2,
    R_DATA = 4'h4,
    R_STOP = 4'h8
  } sbd_rx_state_t;

  typedef enum logic [3:0] {
    T_IDLE = 4'h1,
    T_START = 4'h2,
    T_DATA = 4'h4,
    T_STOP = 4'h8
  } sbd_tx_state_t;

  typedef enum logic [3:0] {
    A_IDLE = 4'h1,
    A_FALL = 4'h2,
    A_RISE = 4'h4,
    A_COUNT = 4'h8
  } sbd_abd_state_t;

endpackage

// ---- core/sbd_serial_port.sv ----
// Purpose: baud generator, data registers, auto-baud and wake for a serial port
// Assumes: one clock sys_clk at 25 MHz, APB slave with one wait state
// Notes: sync mode is master only, full duplex on txd and rxd
`timescale 1ns/100ps
module sbd_serial_port #(
  parameter int ADDR_W = 14
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic sclk,
  output logic sclk_oe_n,
  output logic irq
);

  localparam int IW = ADDR_W - 2;
  localparam int ABD_W_L = sbd_pkg::ABD_W;

  if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 14 and 32");
  end

  sbd_pkg::sbd_baud_ctl_t bc_r, bc_nxt;
  sbd_pkg::sbd_port_ctl_t pc_r, pc_nxt;
  sbd_pkg::sbd_rx_state_t rst_r, rst_nxt;
  sbd_pkg::sbd_tx_state_t tst_r, tst_nxt;
  sbd_pkg::sbd_abd_state_t ast_r, ast_nxt;
  logic [15:0] div_r, div_nxt, brg_r, brg_nxt, eff_div, eff_div_nxt;
  logic [7:0] rx_data_r, rx_data_nxt, tx_data_r, tx_data_nxt;
  logic [7:0] rsh_r, rsh_nxt, tsh_r, tsh_nxt, sync_byte;
  logic [6:0] ros_r, ros_nxt, tos_r, tos_nxt, os_n, os_full, os_half;
  logic [2:0] rbit_r, rbit_nxt, tbit_r, tbit_nxt, aedg_r, aedg_nxt;
  logic [ABD_W_L-1:0] acnt_r, acnt_nxt, abd_q;
  logic [3:0] abd_sh;
  logic [sbd_pkg::IRQ_N-1:0] stat_r, stat_nxt, ien_r, ien_nxt, ev;
  logic [31:0] prdata_nxt;
  logic [15:0] abd_div;
  logic [7:0] bc_rd;
  logic [IW-1:0] widx;
  logic tx_full_r, tx_full_nxt, phase_r, phase_nxt, samp_r, samp_nxt;
  logic txd_nxt, sclk_nxt, sclk_oe_n_nxt, irq_nxt, pready_nxt, pslverr_nxt;
  logic rx_s1, rx_s2, rx_d3, rx_fall, rx_rise, rx_lvl;
  logic tick, div_wr, async_on, rx_norm, rx_async_ev, sync_done, tx_load;
  logic wake_hit, abd_start, abd_done, abd_ovf, wr_en, rd_en, hit;

  // Pin synchroniser; only rx_s2 and later stages feed logic
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_d3 <= 1'b1;
    end else begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
      rx_d3 <= rx_s2;
    end
  end

  assign rx_lvl = rx_s2;
  assign rx_fall = rx_d3 & ~rx_s2;
  assign rx_rise = ~rx_d3 & rx_s2;
  assign async_on = pc_r.port_enable & ~pc_r.mode_sync;
  assign rx_norm = async_on & ~bc_r.wake_on_edge_enable & ~bc_r.autobaud_enable;
  assign wake_hit = async_on & bc_r.wake_on_edge_enable & rx_fall;

  // Ticks per bit from speed and width selects
  always_comb begin
    if (pc_r.high_speed_select && bc_r.wide_divider_select) begin
      os_n = sbd_pkg::OS_FAST;
      abd_sh = sbd_pkg::ABD_SH_FAST;
    end else if (pc_r.high_speed_select || bc_r.wide_divider_select) begin
      os_n = sbd_pkg::OS_MID;
      abd_sh = sbd_pkg::ABD_SH_MID;
    end else begin
      os_n = sbd_pkg::OS_SLOW;
      abd_sh = sbd_pkg::ABD_SH_SLOW;
    end
    os_full = os_n - 7'h01;
    os_half = (os_n >> 1) - 7'h01;
  end

  // Baud counter
  always_comb begin
    eff_div = bc_r.wide_divider_select ? div_r : {8'h00, div_r[7:0]};
    eff_div_nxt = bc_r.wide_divider_select ? div_nxt : {8'h00, div_nxt[7:0]};
    tick = pc_r.port_enable & ~div_wr & (brg_r == 16'h0000);
    if (!pc_r.port_enable || div_wr) begin
      brg_nxt = eff_div_nxt;
    end else if (brg_r == 16'h0000) begin
      brg_nxt = eff_div;
    end else begin
      brg_nxt = brg_r - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      brg_r <= sbd_pkg::RST_DIV;
    end else begin
      brg_r <= brg_nxt;
    end
  end

  // Async receiver
  always_comb begin
    rst_nxt = rst_r;
    ros_nxt = ros_r;
    rbit_nxt = rbit_r;
    rsh_nxt = rsh_r;
    rx_data_nxt = rx_data_r;
    rx_async_ev = 1'b0;
    if (!rx_norm) begin
      rst_nxt = sbd_pkg::R_IDLE;
    end else begin
      case (rst_r)
        sbd_pkg::R_IDLE: begin
          if (rx_fall) begin
            rst_nxt = sbd_pkg::R_START;
            ros_nxt = 7'h00;
          end
        end
        sbd_pkg::R_START: begin
          if (tick && ros_r == os_half) begin
            ros_nxt = 7'h00;
            rbit_nxt = 3'h0;
            // Glitch shorter than half a bit is not a start
            rst_nxt = rx_lvl ? sbd_pkg::R_IDLE : sbd_pkg::R_DATA;
          end else if (tick) begin
            ros_nxt = ros_r + 7'h01;
          end
        end
        sbd_pkg::R_DATA: begin
          if (tick && ros_r == os_full) begin
            ros_nxt = 7'h00;
            rsh_nxt = {rx_lvl, rsh_r[7:1]};
            rbit_nxt = rbit_r + 3'h1;
            if (rbit_r == sbd_pkg::LAST_BIT) begin
              rst_nxt = sbd_pkg::R_STOP;
            end
          end else if (tick) begin
            ros_nxt = ros_r + 7'h01;
          end
        end
        sbd_pkg::R_STOP: begin
          if (tick && ros_r == os_full) begin
            rx_data_nxt = rsh_r;
            rx_async_ev = 1'b1;
            rst_nxt = sbd_pkg::R_IDLE;
          end else if (tick) begin
            ros_nxt = ros_r + 7'h01;
          end
        end
        default: rst_nxt = sbd_pkg::R_IDLE;
      endcase
    end
    if (sync_done) begin
      rx_data_nxt = sync_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_r <= sbd_pkg::R_IDLE;
      ros_r <= 7'h00;
      rbit_r <= 3'h0;
      rsh_r <= sbd_pkg::RST_BYTE;
      rx_data_r <= sbd_pkg::RST_BYTE;
    end else begin
      rst_r <= rst_nxt;
      ros_r <= ros_nxt;
      rbit_r <= rbit_nxt;
      rsh_r <= rsh_nxt;
      rx_data_r <= rx_data_nxt;
    end
  end

  // Transmitter; in sync mode also shifts the received byte in
  assign sync_byte = {samp_r, tsh_r[7:1]};

  always_comb begin
    tst_nxt = tst_r;
    tos_nxt = tos_r;
    tbit_nxt = tbit_r;
    tsh_nxt = tsh_r;
    phase_nxt = phase_r;
    samp_nxt = samp_r;
    txd_nxt = txd;
    tx_load = 1'b0;
    sync_done = 1'b0;
    if (!pc_r.port_enable) begin
      tst_nxt = sbd_pkg::T_IDLE;
      phase_nxt = 1'b0;
      txd_nxt = ~bc_r.polarity_edge_select;
    end else begin
      case (tst_r)
        sbd_pkg::T_IDLE: begin
          phase_nxt = 1'b0;
          if (!pc_r.mode_sync) begin
            txd_nxt = ~bc_r.polarity_edge_select;
          end
          if (tx_full_r) begin
            tx_load = 1'b1;
            tsh_nxt = tx_data_r;
            tos_nxt = 7'h00;
            tbit_nxt = 3'h0;
            tst_nxt = pc_r.mode_sync ? sbd_pkg::T_DATA : sbd_pkg::T_START;
          end
        end
        sbd_pkg::T_START: begin
          txd_nxt = bc_r.polarity_edge_select;
          if (tick && tos_r == os_full) begin
            tos_nxt = 7'h00;
            tst_nxt = sbd_pkg::T_DATA;
          end else if (tick) begin
            tos_nxt = tos_r + 7'h01;
          end
        end
        sbd_pkg::T_DATA: begin
          if (pc_r.mode_sync) begin
            txd_nxt = tsh_r[0];
            if (tick && !phase_r) begin
              phase_nxt = 1'b1;
              samp_nxt = rx_lvl;
            end else if (tick) begin
              phase_nxt = 1'b0;
              tsh_nxt = sync_byte;
              tbit_nxt = tbit_r + 3'h1;
              if (tbit_r == sbd_pkg::LAST_BIT) begin
                sync_done = 1'b1;
                tst_nxt = sbd_pkg::T_IDLE;
              end
            end
          end else begin
            txd_nxt = tsh_r[0] ^ bc_r.polarity_edge_select;
            if (tick && tos_r == os_full) begin
              tos_nxt = 7'h00;
              tsh_nxt = {1'b0, tsh_r[7:1]};
              tbit_nxt = tbit_r + 3'h1;
              if (tbit_r == sbd_pkg::LAST_BIT) begin
                tst_nxt = sbd_pkg::T_STOP;
              end
            end else if (tick) begin
              tos_nxt = tos_r + 7'h01;
            end
          end
        end
        sbd_pkg::T_STOP: begin
          txd_nxt = ~bc_r.polarity_edge_select;
          if (tick && tos_r == os_full) begin
            tst_nxt = sbd_pkg::T_IDLE;
          end else if (tick) begin
            tos_nxt = tos_r + 7'h01;
          end
        end
        default: tst_nxt = sbd_pkg::T_IDLE;
      endcase
    end
    // Leading edge is the sample edge: rising when polarity is one
    sclk_nxt = ~bc_r.polarity_edge_select ^ (pc_r.mode_sync & phase_nxt);
    sclk_oe_n_nxt = ~(pc_r.port_enable & pc_r.mode_sync);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tst_r <= sbd_pkg::T_IDLE;
      tos_r <= 7'h00;
      tbit_r <= 3'h0;
      tsh_r <= sbd_pkg::RST_BYTE;
      phase_r <= 1'b0;
      samp_r <= 1'b0;
      txd <= 1'b1;
      sclk <= 1'b1;
      sclk_oe_n <= 1'b1;
    end else begin
      tst_r <= tst_nxt;
      tos_r <= tos_nxt;
      tbit_r <= tbit_nxt;
      tsh_r <= tsh_nxt;
      phase_r <= phase_nxt;
      samp_r <= samp_nxt;
      txd <= txd_nxt;
      sclk <= sclk_nxt;
      sclk_oe_n <= sclk_oe_n_nxt;
    end
  end

  // Auto-baud: times eight bit periods of a 0x55 character
  always_comb begin
    ast_nxt = ast_r;
    acnt_nxt = acnt_r;
    aedg_nxt = aedg_r;
    abd_start = 1'b0;
    abd_done = 1'b0;
    abd_ovf = 1'b0;
    abd_q = acnt_r >> abd_sh;
    abd_div = (abd_q == '0) ? 16'h0000 : 16'(abd_q - ABD_W_L'(1));
    if (!(async_on && bc_r.autobaud_enable)) begin
      ast_nxt = sbd_pkg::A_IDLE;
    end else begin
      case (ast_r)
        sbd_pkg::A_IDLE: begin
          abd_start = 1'b1;
          ast_nxt = sbd_pkg::A_FALL;
        end
        sbd_pkg::A_FALL: begin
          if (rx_fall) begin
            ast_nxt = sbd_pkg::A_RISE;
          end
        end
        sbd_pkg::A_RISE: begin
          if (rx_rise) begin
            acnt_nxt = '0;
            aedg_nxt = 3'h0;
            ast_nxt = sbd_pkg::A_COUNT;
          end
        end
        sbd_pkg::A_COUNT: begin
          acnt_nxt = acnt_r + ABD_W_L'(1);
          if (&acnt_r) begin
            abd_ovf = 1'b1;
            ast_nxt = sbd_pkg::A_IDLE;
          end else if (rx_rise && aedg_r == sbd_pkg::ABD_LAST_RISE) begin
            ast_nxt = sbd_pkg::A_IDLE;
            // Result too big for the selected counter width
            if (abd_q > (bc_r.wide_divider_select ? ABD_W_L'(32'h10000) : ABD_W_L'(32'h100))) begin
              abd_ovf = 1'b1;
            end else begin
              abd_done = 1'b1;
            end
          end else if (rx_rise) begin
            aedg_nxt = aedg_r + 3'h1;
          end
        end
        default: ast_nxt = sbd_pkg::A_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ast_r <= sbd_pkg::A_IDLE;
      acnt_r <= '0;
      aedg_r <= 3'h0;
    end else begin
      ast_r <= ast_nxt;
      acnt_r <= acnt_nxt;
      aedg_r <= aedg_nxt;
    end
  end

  // Register file and APB slave
  assign widx = paddr[ADDR_W-1:2];
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & pready & ~pwrite;

  always_comb begin
    bc_nxt = bc_r;
    pc_nxt = pc_r;
    div_nxt = div_r;
    tx_data_nxt = tx_data_r;
    tx_full_nxt = tx_full_r & ~tx_load;
    ien_nxt = ien_r;
    stat_nxt = stat_r;
    div_wr = 1'b0;
    hit = 1'b1;
    bc_rd = 8'h00;
    prdata_nxt = prdata;
    bc_rd[sbd_pkg::BC_OVF] = bc_r.autobaud_overflow_flag;
    bc_rd[sbd_pkg::BC_IDLE] = pc_r.mode_sync | (rst_r == sbd_pkg::R_IDLE);
    bc_rd[sbd_pkg::BC_POL] = bc_r.polarity_edge_select;
    bc_rd[sbd_pkg::BC_WIDE] = bc_r.wide_divider_select;
    bc_rd[sbd_pkg::BC_WAKE] = bc_r.wake_on_edge_enable;
    bc_rd[sbd_pkg::BC_ABD] = bc_r.autobaud_enable;
    if (widx == IW'(sbd_pkg::IDX_RX_DATA)) begin
      prdata_nxt = {24'h000000, rx_data_r};
      if (rd_en) begin
        stat_nxt[sbd_pkg::IRQ_RX] = 1'b0;
      end
    end else if (widx == IW'(sbd_pkg::IDX_TX_DATA)) begin
      prdata_nxt = {24'h000000, tx_data_r};
      if (wr_en) begin
        tx_data_nxt = pwdata[7:0];
        tx_full_nxt = 1'b1;
      end
    end else if (widx == IW'(sbd_pkg::IDX_DIV_LO)) begin
      prdata_nxt = {24'h000000, div_r[7:0]};
      if (wr_en) begin
        div_nxt[7:0] = pwdata[7:0];
        div_wr = 1'b1;
      end
    end else if (widx == IW'(sbd_pkg::IDX_DIV_HI)) begin
      prdata_nxt = {24'h000000, div_r[15:8]};
      if (wr_en) begin
        div_nxt[15:8] = pwdata[7:0];
        div_wr = 1'b1;
      end
    end else if (widx == IW'(sbd_pkg::IDX_BAUD_CTL)) begin
      prdata_nxt = {24'h000000, bc_rd};
      if (wr_en) begin
        bc_nxt.polarity_edge_select = pwdata[sbd_pkg::BC_POL];
        bc_nxt.wide_divider_select = pwdata[sbd_pkg::BC_WIDE];
        bc_nxt.wake_on_edge_enable = pwdata[sbd_pkg::BC_WAKE];
        bc_nxt.autobaud_enable = pwdata[sbd_pkg::BC_ABD];
      end
    end else if (widx == IW'(sbd_pkg::IDX_IRQ_STAT)) begin
      prdata_nxt = {29'h00000000, stat_r};
    end else if (widx == IW'(sbd_pkg::IDX_IRQ_EN)) begin
      prdata_nxt = {29'h00000000, ien_r};
      if (wr_en) begin
        ien_nxt = pwdata[sbd_pkg::IRQ_N-1:0];
      end
    end else if (widx == IW'(sbd_pkg::IDX_IRQ_CLR)) begin
      prdata_nxt = 32'h00000000;
      if (wr_en) begin
        stat_nxt = stat_r & ~pwdata[sbd_pkg::IRQ_N-1:0];
      end
    end else if (widx == IW'(sbd_pkg::IDX_PORT_CTL)) begin
      prdata_nxt = {29'h00000000, pc_r};
      if (wr_en) begin
        pc_nxt.port_enable = pwdata[sbd_pkg::PC_EN];
        pc_nxt.mode_sync = pwdata[sbd_pkg::PC_SYNC];
        pc_nxt.high_speed_select = pwdata[sbd_pkg::PC_HS];
      end
    end else begin
      hit = 1'b0;
      prdata_nxt = 32'h00000000;
    end
    // Hardware updates follow software so they win in the same cycle
    if (abd_start) begin
      bc_nxt.autobaud_overflow_flag = 1'b0;
    end
    if (abd_done) begin
      div_nxt = abd_div;
      div_wr = 1'b1;
      bc_nxt.autobaud_enable = 1'b0;
    end
    if (abd_ovf) begin
      bc_nxt.autobaud_overflow_flag = 1'b1;
      bc_nxt.autobaud_enable = 1'b0;
    end
    if (wake_hit) begin
      bc_nxt.wake_on_edge_enable = 1'b0;
    end
    ev = '0;
    ev[sbd_pkg::IRQ_RX] = rx_async_ev | sync_done | wake_hit | abd_done;
    ev[sbd_pkg::IRQ_TX] = tx_load;
    ev[sbd_pkg::IRQ_OVF] = abd_ovf;
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & ien_nxt);
    pready_nxt = psel & penable & ~pready;
    pslverr_nxt = pready_nxt & ~hit;
    if (!pready_nxt) begin
      prdata_nxt = prdata;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bc_r <= '0;
      pc_r <= '0;
      div_r <= sbd_pkg::RST_DIV;
      tx_data_r <= sbd_pkg::RST_BYTE;
      tx_full_r <= 1'b0;
      ien_r <= '0;
      stat_r <= '0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      bc_r <= bc_nxt;
      pc_r <= pc_nxt;
      div_r <= div_nxt;
      tx_data_r <= tx_data_nxt;
      tx_full_r <= tx_full_nxt;
      ien_r <= ien_nxt;
      stat_r <= stat_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      irq <= irq_nxt;
    end
  end

endmodule

// ---- bench/sbd_serial_port_properties.sv ----
// Purpose: port-level checks of the serial port block
// Assumes: default ADDR_W, one clock domain
// Notes: control shadows are rebuilt from APB writes
`timescale 1ns/100ps
module sbd_serial_port_properties #(
  parameter int ADDR_W = 14
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic sclk,
  input wire logic sclk_oe_n,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [11:0] idx;
  logic mapped;
  logic land;
  logic rd_ok;
  logic [7:0] tx_r;
  logic [1:0] pc_r;
  logic [2:0] quiet_r;
  assign idx = paddr[ADDR_W-1:2];
  assign land = psel && penable && pready && pwrite;
  assign rd_ok = pready && !pwrite;
  assign mapped = idx inside {sbd_pkg::IDX_RX_DATA, sbd_pkg::IDX_TX_DATA,
    sbd_pkg::IDX_DIV_LO, sbd_pkg::IDX_DIV_HI, sbd_pkg::IDX_BAUD_CTL, sbd_pkg::IDX_IRQ_STAT,
    sbd_pkg::IDX_IRQ_EN, sbd_pkg::IDX_IRQ_CLR, sbd_pkg::IDX_PORT_CTL};
  // Output regs lag a landed write, so wait a few quiet cycles
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_r <= 8'h00;
      pc_r <= 2'h0;
      quiet_r <= 3'h0;
    end else begin
      if (land && idx == sbd_pkg::IDX_TX_DATA) tx_r <= pwdata[7:0];
      if (land && idx == sbd_pkg::IDX_PORT_CTL) pc_r <= pwdata[1:0];
      quiet_r <= land ? 3'h0 : (quiet_r == 3'h7 ? 3'h7 : quiet_r + 3'h1);
    end
  end
  property p_wait; psel && !penable |-> ##2 pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not two cycles after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("pready outside access phase");
  property p_err; pready |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("slave error wrong for index");
  property p_err_dat; pslverr |-> prdata == 32'h0000_0000; endproperty
  a_err_dat: assert property (p_err_dat) else $error("data on refused read");
  property p_hold; !pready |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved between reads");
  property p_tx; rd_ok && idx == sbd_pkg::IDX_TX_DATA |-> prdata == {24'h0, tx_r}; endproperty
  a_tx: assert property (p_tx) else $error("transmit data readback wrong");
  property p_rx; rd_ok && idx == sbd_pkg::IDX_RX_DATA |-> prdata[31:8] == 24'h0; endproperty
  a_rx: assert property (p_rx) else $error("receive data wider than a byte");
  property p_oe; quiet_r >= 3'h3 |-> sclk_oe_n == !(pc_r[0] && pc_r[1]); endproperty
  a_oe: assert property (p_oe) else $error("shift clock enable wrong for mode");
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
  c_sync: cover property (!sclk_oe_n);
endmodule

// ---- bench/sbd_peer.sv ----
// Purpose: remote serial transceiver on txd and rxd
// Assumes: 8N1 frames, bit length in sys_clk cycles
// Notes: rxd idles high as a pulled-up line would
`timescale 1ns/100ps
module sbd_peer (
  input wire logic sys_clk,
  input wire logic txd,
  input wire logic send,
  input wire logic listen,
  input wire logic inv,
  input wire logic [7:0] tx_byte,
  input wire logic [15:0] bit_clks,
  output logic rxd,
  output logic busy,
  output logic [7:0] got
);
  logic [9:0] fr;
  logic [7:0] sh;
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (send === 1'b1) begin
        busy <= 1'b1;
        fr = {1'b1, tx_byte, 1'b0};
        for (int i = 0; i < 10; i++) begin
          rxd <= fr[i];
          repeat (bit_clks) @(posedge sys_clk);
        end
        busy <= 1'b0;
      end
    end
  end
  // Armed only once the line level is settled
  initial begin
    got = 8'h00;
    sh = 8'h00;
    forever begin
      @(posedge sys_clk);
      if (listen === 1'b1 && (txd ^ inv) === 1'b0) begin
        repeat (bit_clks / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (bit_clks) @(posedge sys_clk);
          sh = {txd ^ inv, sh[7:1]};
        end
        repeat (bit_clks) @(posedge sys_clk);
        got <= sh;
      end
    end
  end
endmodule

// ---- bench/sbd_serial_port_tb.sv ----
// Purpose: register and line tests of the serial port block
// Assumes: one APB wait state, tick every div+1 clocks
// Notes: fast setup gives 8 clocks per bit
`timescale 1ns/100ps
module sbd_serial_port_tb;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic rxd, txd, sclk, sclk_oe_n, irq, send, listen, inv, busy, er;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] tx_byte, got;
  logic [15:0] bit_clks;
  int fails, checks;
  sbd_serial_port u_sbd_serial_port (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .sclk(sclk),
    .sclk_oe_n(sclk_oe_n), .irq(irq));
  sbd_peer u_sbd_peer (.sys_clk(sys_clk), .txd(txd), .send(send), .listen(listen),
    .inv(inv), .tx_byte(tx_byte), .bit_clks(bit_clks), .rxd(rxd), .busy(busy), .got(got));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task end_sim;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      end_sim;
    end
    @(posedge sys_clk);
  endtask
  task wr(input logic [11:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  task rdc(input logic [11:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0000_0000);
    cmp(rd, e);
  endtask
  task go(input logic [7:0] b);
    tx_byte <= b;
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Bounded wait on the peer or on a captured byte
  task fin(input logic want_byte);
    int n;
    n = 0;
    while ((want_byte ? got === 8'h00 : busy === 1'b1) && n < 50000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50000) begin
      fails++;
      end_sim;
    end
  endtask
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, send, listen, inv} = 6'h00;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    tx_byte = 8'h00;
    bit_clks = 16'h0008;
    fails = 0;
    checks = 0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rdc(sbd_pkg::IDX_RX_DATA, 32'h0000_0000);
    rdc(sbd_pkg::IDX_DIV_HI, 32'h0000_0000);
    rdc(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0040);
    cmp(32'(txd), 32'h0000_0001);
    apb(1'b0, 12'hF9C, 32'h0000_0000);
    cmp(32'(er), 32'h0000_0001);
    wr(sbd_pkg::IDX_RX_DATA, 32'h0000_0077);
    rdc(sbd_pkg::IDX_RX_DATA, 32'h0000_0000);
    wr(sbd_pkg::IDX_DIV_HI, 32'h0000_0012);
    wr(sbd_pkg::IDX_DIV_LO, 32'h0000_0001);
    rdc(sbd_pkg::IDX_DIV_HI, 32'h0000_0012);
    wr(sbd_pkg::IDX_DIV_HI, 32'h0000_0000);
    wr(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0008);
    wr(sbd_pkg::IDX_IRQ_EN, 32'h0000_0001);
    wr(sbd_pkg::IDX_PORT_CTL, 32'h0000_0005);
    go(8'hA5);
    rdc(sbd_pkg::IDX_DIV_LO, 32'h0000_0001);
    rdc(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0008);
    fin(1'b0);
    cmp(32'(irq), 32'h0000_0001);
    rdc(sbd_pkg::IDX_RX_DATA, 32'h0000_00A5);
    cmp(32'(irq), 32'h0000_0000);
    // Wide off: a high byte of 1 must not slow the bit
    wr(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0000);
    wr(sbd_pkg::IDX_DIV_HI, 32'h0000_0001);
    bit_clks = 16'h0020;
    go(8'h3C);
    fin(1'b0);
    rdc(sbd_pkg::IDX_RX_DATA, 32'h0000_003C);
    wr(sbd_pkg::IDX_IRQ_EN, 32'h0000_0000);
    wr(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0002);
    go(8'hFF);
    fin(1'b0);
    rdc(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0040);
    rdc(sbd_pkg::IDX_IRQ_STAT, 32'h0000_0001);
    cmp(32'(irq), 32'h0000_0000);
    wr(sbd_pkg::IDX_IRQ_CLR, 32'h0000_0001);
    rdc(sbd_pkg::IDX_IRQ_STAT, 32'h0000_0000);
    rdc(sbd_pkg::IDX_RX_DATA, 32'h0000_003C);
    wr(sbd_pkg::IDX_DIV_HI, 32'h0000_0000);
    wr(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0018);
    rdc(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0058);
    cmp(32'(txd), 32'h0000_0000);
    inv = 1'b1;
    bit_clks = 16'h0008;
    listen = 1'b1;
    wr(sbd_pkg::IDX_TX_DATA, 32'h0000_0096);
    fin(1'b1);
    cmp(32'(got), 32'h0000_0096);
    rdc(sbd_pkg::IDX_TX_DATA, 32'h0000_0096);
    listen = 1'b0;
    wr(sbd_pkg::IDX_PORT_CTL, 32'h0000_0003);
    rdc(sbd_pkg::IDX_DIV_HI, 32'h0000_0000);
    cmp(32'(sclk_oe_n), 32'h0000_0000);
    cmp(32'(sclk), 32'h0000_0000);
    // Sync byte: leading edges sample the idle-high line
    wr(sbd_pkg::IDX_TX_DATA, 32'h0000_005A);
    repeat (40) @(posedge sys_clk);
    rdc(sbd_pkg::IDX_RX_DATA, 32'h0000_00FF);
    cmp(32'(sclk), 32'h0000_0000);
    // Auto-baud on 0x55: 8 bits of 34 clocks, 4 ticks a bit
    wr(sbd_pkg::IDX_PORT_CTL, 32'h0000_0005);
    wr(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0009);
    bit_clks = 16'h0022;
    go(8'h55);
    fin(1'b0);
    rdc(sbd_pkg::IDX_DIV_LO, 32'h0000_0007);
    rdc(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0048);
    wr(sbd_pkg::IDX_BAUD_CTL, 32'h0000_0001);
    bit_clks = 16'd4200;
    go(8'h55);
    fin(1'b0);
    rdc(sbd_pkg::IDX_BAUD_CTL, 32'h0000_00C0);
    end_sim;
  end
endmodule
bind sbd_serial_port sbd_serial_port_properties #(.ADDR_W(ADDR_W)) u_sbd_serial_port_properties (
  .sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .txd(txd), .sclk(sclk), .sclk_oe_n(sclk_oe_n), .irq(irq));
